// ---- delta_snapshot.sv ----
// Frozen X and Y displacement values captured on a status read
`timescale 1ns/1ps

module delta_snapshot (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Capture strobe and live accumulator values
   input  wire logic       snap_load,
   input  wire logic [7:0] live_x,
   input  wire logic [7:0] live_y,
   // Frozen values
   output logic      [7:0] frozen_x,
   output logic      [7:0] frozen_y
);

   typedef struct packed {
      logic [1:0][7:0] axis;
   } snap_t;

   snap_t st_reg;
   snap_t st_next;
   logic [1:0][7:0] live;

   assign live[0] = live_x;
   assign live[1] = live_y;

   // ==========================================================
   // Capture: a new load simply overwrites an unread snapshot
   always_comb begin
      st_next = st_reg;
      if (snap_load) begin
         st_next.axis = live;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   genvar i;
   for (i = 0; i < 2; i++) begin : g_hold
      // Value only moves on a capture strobe
      snap_hold_a: assert property (
         @(posedge clk_sys) disable iff (rst)
         !snap_load |=> $stable(st_reg.axis[i]))
         else $error("frozen displacement changed without capture");
   end

   assign frozen_x = st_reg.axis[0];
   assign frozen_y = st_reg.axis[1];

endmodule

// ---- host_poller.sv ----
// Mouse controller model that polls the motion status register port
`timescale 1ns/1ps

module host_poller (
   // Clock
   input  wire logic       clk_sys,
   // Register read port
   output logic            rd_en,
   output logic      [6:0] rd_addr,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data
);
   initial begin
      rd_en   = 1'b0;
      rd_addr = 7'h7f;
   end

   // ==========================================================
   // One read: a single strobe cycle, then wait for the answer
   task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(negedge clk_sys);
      rd_en   = 1'b1;
      rd_addr = a;
      @(negedge clk_sys);
      rd_en   = 1'b0;
      // Released address never keeps looking like the last request
      rd_addr = ~a;
      while (rd_valid !== 1'b1 && n < 8) begin
         @(negedge clk_sys);
         n++;
      end
      // A missing answer must never pass as stale data
      d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
   endtask

   // ==========================================================
   // Two reads on consecutive cycles, each answer taken as it stands
   task automatic read_pair(input logic [6:0] a0, a1,
                            output logic [7:0] d0, d1);
      @(negedge clk_sys);
      rd_en   = 1'b1;
      rd_addr = a0;
      @(negedge clk_sys);
      d0      = (rd_valid === 1'b1) ? rd_data : 8'hxx;
      rd_addr = a1;
      @(negedge clk_sys);
      d1      = (rd_valid === 1'b1) ? rd_data : 8'hxx;
      rd_en   = 1'b0;
      rd_addr = ~a1;
   endtask
endmodule

// ---- motion_status_pkg.sv ----
// Register map, field positions and reset values of the motion status logic
package motion_status_pkg;

   // ==========================================================
   // Register addresses on the serial register port
   localparam logic [6:0] ADDR_STATUS  = 7'h02;
   localparam logic [6:0] ADDR_DELTA_X = 7'h03;
   localparam logic [6:0] ADDR_DELTA_Y = 7'h04;

   // ==========================================================
   // Status field positions
   localparam int MOTION_BIT = 7;
   localparam int YOVF_BIT   = 4;
   localparam int XOVF_BIT   = 3;
   localparam int CPI_MSB    = 2;
   localparam int CPI_LSB    = 1;

   // ==========================================================
   // Reset values and answers
   localparam logic       FLAG_RST    = 1'b0;
   localparam logic [7:0] DATA_RST    = 8'h00;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;

endpackage

// ---- motion_status_readout.sv ----
// Motion status register, overflow flags and displacement freeze logic
//
// Functional notes
// - Motion bit 7 set on motion since last status read, else clear.
// - Bits 4 and 3 report Y and X overflow since last status read.
// - Bits 2:1 show the selected counts-per-inch resolution.
// - Status read freezes X and Y displacement for later reads.
// - Second status read before delta reads discards previous frozen data.
// - Overflow flags read 0 by default, 1 after an overflow.
`timescale 1ns/1ps

module motion_status_readout (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Register read port from the serial front end
   input  wire logic       rd_en,
   input  wire logic [6:0] rd_addr,
   output logic            rd_valid,
   output logic      [7:0] rd_data,
   // Accumulator side
   input  wire logic       motion_event,
   input  wire logic       x_ovf_event,
   input  wire logic       y_ovf_event,
   input  wire logic [7:0] live_x,
   input  wire logic [7:0] live_y,
   output logic            accum_clear,
   // Configuration
   input  wire logic [1:0] cpi_select_field,
   // Snapshot state
   output logic            snap_pending
);

   typedef struct packed {
      logic       motion;
      logic       x_accum_overflow_flag;
      logic       y_accum_overflow_flag;
      logic       pending;
      logic       valid;
      logic [7:0] data;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic [7:0] frozen_x;
   logic [7:0] frozen_y;
   logic       status_rd;
   logic       x_rd;
   logic       y_rd;
   logic [7:0] status_word;

   function automatic logic hit(input logic       en,
                                input logic [6:0] addr,
                                input logic [6:0] target);
      return en && (addr == target);
   endfunction

   assign status_rd = hit(rd_en, rd_addr, motion_status_pkg::ADDR_STATUS);
   assign x_rd      = hit(rd_en, rd_addr, motion_status_pkg::ADDR_DELTA_X);
   assign y_rd      = hit(rd_en, rd_addr, motion_status_pkg::ADDR_DELTA_Y);

   // ==========================================================
   // Status word assembly
   always_comb begin
      status_word = 8'h00;
      status_word[motion_status_pkg::MOTION_BIT] = st_reg.motion;
      status_word[motion_status_pkg::YOVF_BIT] =
         st_reg.y_accum_overflow_flag;
      status_word[motion_status_pkg::XOVF_BIT] =
         st_reg.x_accum_overflow_flag;
      status_word[motion_status_pkg::CPI_MSB:motion_status_pkg::CPI_LSB] =
         cpi_select_field;
   end

   // ==========================================================
   // Flags, snapshot bookkeeping and read data
   always_comb begin
      st_next = st_reg;
      st_next.valid = rd_en;
      // Sticky flags; an event in the read cycle survives the clear
      if (status_rd) begin
         st_next.motion = motion_event;
         st_next.x_accum_overflow_flag = x_ovf_event;
         st_next.y_accum_overflow_flag = y_ovf_event;
         st_next.pending = 1'b1;
      end else begin
         st_next.motion = st_reg.motion | motion_event;
         st_next.x_accum_overflow_flag =
            st_reg.x_accum_overflow_flag | x_ovf_event;
         st_next.y_accum_overflow_flag =
            st_reg.y_accum_overflow_flag | y_ovf_event;
         if (y_rd) begin
            st_next.pending = 1'b0;
         end
      end
      if (status_rd) begin
         st_next.data = status_word;
      end else if (x_rd) begin
         st_next.data = frozen_x;
      end else if (y_rd) begin
         st_next.data = frozen_y;
      end else if (rd_en) begin
         st_next.data = motion_status_pkg::UNMAPPED_RD;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg.motion                <= motion_status_pkg::FLAG_RST;
         st_reg.x_accum_overflow_flag <= motion_status_pkg::FLAG_RST;
         st_reg.y_accum_overflow_flag <= motion_status_pkg::FLAG_RST;
         st_reg.pending               <= 1'b0;
         st_reg.valid                 <= 1'b0;
         st_reg.data                  <= motion_status_pkg::DATA_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Freeze: a repeated status read overwrites unread deltas
   delta_snapshot u_snap (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .snap_load (status_rd),
      .live_x    (live_x),
      .live_y    (live_y),
      .frozen_x  (frozen_x),
      .frozen_y  (frozen_y)
   );

   // Captured motion leaves the accumulator so the next report is fresh
   assign accum_clear  = status_rd;
   assign rd_valid     = st_reg.valid;
   assign rd_data      = st_reg.data;
   assign snap_pending = st_reg.pending;

   // ==========================================================
   // Checks
   // Flags are checked one edge after their cause, where the register shows it
   motion_set_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      motion_event |=> st_reg.motion)
      else $error("motion event did not set flag");

   motion_clear_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      status_rd && !motion_event |=> !st_reg.motion)
      else $error("motion flag not cleared by status read");

   motion_hold_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      st_reg.motion && !status_rd |=> st_reg.motion)
      else $error("motion flag dropped without status read");

   overflow_report_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      status_rd |=> rd_data[4] == $past(st_reg.y_accum_overflow_flag)
                 && rd_data[3] == $past(st_reg.x_accum_overflow_flag))
      else $error("overflow bits wrong in status word");

   overflow_clear_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      status_rd && !x_ovf_event && !y_ovf_event
      |=> !st_reg.x_accum_overflow_flag && !st_reg.y_accum_overflow_flag)
      else $error("overflow flags not cleared by status read");

   cpi_report_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      status_rd |=> rd_data[2:1] == $past(cpi_select_field))
      else $error("resolution bits wrong in status word");

   freeze_read_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      status_rd ##1 (rd_en && rd_addr == motion_status_pkg::ADDR_DELTA_X)
      |=> rd_data == $past(live_x, 2))
      else $error("delta X read did not return snapshot");

   delta_y_read_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      y_rd |=> rd_data == $past(frozen_y))
      else $error("delta Y read did not return snapshot");

   pending_drop_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      y_rd |=> !snap_pending)
      else $error("snapshot still pending after delta Y read");

   refreeze_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      status_rd ##1 status_rd |=> frozen_y == $past(live_y))
      else $error("second status read kept old snapshot");

   pending_set_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      status_rd |=> snap_pending)
      else $error("status read did not mark snapshot pending");

   overflow_sticky_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      st_reg.x_accum_overflow_flag && !status_rd
      |=> st_reg.x_accum_overflow_flag)
      else $error("overflow flag dropped without status read");

   y_overflow_sticky_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      st_reg.y_accum_overflow_flag && !status_rd
      |=> st_reg.y_accum_overflow_flag)
      else $error("Y overflow flag dropped without status read");

   x_overflow_set_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      x_ovf_event |=> st_reg.x_accum_overflow_flag)
      else $error("X overflow event did not set flag");

   y_overflow_set_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      y_ovf_event |=> st_reg.y_accum_overflow_flag)
      else $error("Y overflow event did not set flag");

   reserved_zero_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      status_rd |=> rd_valid && rd_data[6:5] == 2'b00 && !rd_data[0])
      else $error("reserved status bits not zero");

   unmapped_zero_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      rd_en && !status_rd && !x_rd && !y_rd
      |=> rd_data == motion_status_pkg::UNMAPPED_RD)
      else $error("unmapped read did not answer zero");

endmodule

// ---- motion_status_readout_test.sv ----
// Self-checking bench for the motion status readout
`timescale 1ns/1ps

module motion_status_readout_test;
   logic       clk_sys = 1'b0;
   logic       rst = 1'b1;
   logic       rd_en, rd_valid, accum_clear, snap_pending;
   logic       motion_event = 1'b0, x_ovf_event = 1'b0, y_ovf_event = 1'b0;
   logic       m, xo, yo;
   logic [6:0] rd_addr;
   logic [7:0] rd_data, s, s2, x, y, ex, ey, clr_exp;
   logic [7:0] live_x = 8'h00, live_y = 8'h00;
   logic [1:0] cpi_select_field = 2'h0;
   logic [6:0] holes [5] = '{7'h00, 7'h01, 7'h05, 7'h06, 7'h7f};
   int         fail_count = 0, total_checks = 0;

   always #50 clk_sys = ~clk_sys;

   motion_status_readout uut (.clk_sys(clk_sys), .rst(rst), .rd_en(rd_en),
      .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
      .motion_event(motion_event), .x_ovf_event(x_ovf_event),
      .y_ovf_event(y_ovf_event), .live_x(live_x), .live_y(live_y),
      .accum_clear(accum_clear), .cpi_select_field(cpi_select_field),
      .snap_pending(snap_pending));

   host_poller host (.clk_sys(clk_sys), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_valid(rd_valid), .rd_data(rd_data));

   function automatic logic [7:0] stat(input logic a, b, c,
                                       input logic [1:0] r);
      return {a, 2'h0, b, c, r, 1'h0};
   endfunction

   task automatic check(input string what, input logic [7:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ==========================================================
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #2_000_000;
      fail_count++;
      give_verdict();
   end

   // Accumulator restart strobe stands only in the cycle of a status read
   always @(posedge clk_sys) begin
      clr_exp = {7'h00, rd_en && rd_addr == motion_status_pkg::ADDR_STATUS};
      if (!rst) begin
         check("accum_clear", clr_exp, {7'h00, accum_clear});
      end
   end

   initial begin
      void'($urandom(23951));
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      host.read_reg(motion_status_pkg::ADDR_STATUS, s);
      check("status_rst", stat(1'h0, 1'h0, 1'h0, 2'h0), s);
      $display("test reset done");
      for (int i = 0; i < 15; i++) begin
         m = 1'($urandom);
         xo = 1'($urandom);
         yo = 1'($urandom);
         cpi_select_field = 2'(i % 3);
         live_x = 8'($urandom);
         live_y = 8'($urandom);
         @(negedge clk_sys);
         motion_event = m;
         x_ovf_event = xo;
         y_ovf_event = yo;
         @(negedge clk_sys);
         motion_event = 1'b0;
         x_ovf_event = 1'b0;
         y_ovf_event = 1'b0;
         // Status first, as the controller always does
         host.read_reg(motion_status_pkg::ADDR_STATUS, s);
         check("status", stat(m, yo, xo, cpi_select_field), s);
         ex = 8'($urandom);
         ey = 8'($urandom);
         live_x = ex;
         live_y = ey;
         // Second status read drops the unread pair, flags now clear
         host.read_reg(motion_status_pkg::ADDR_STATUS, s);
         check("status2", stat(1'h0, 1'h0, 1'h0, cpi_select_field), s);
         live_x = ~ex;
         live_y = ~ey;
         host.read_reg(motion_status_pkg::ADDR_DELTA_X, x);
         check("pending", 8'h01, {7'h00, snap_pending});
         host.read_reg(motion_status_pkg::ADDR_DELTA_Y, y);
         check("delta_x", ex, x);
         check("delta_y", ey, y);
         check("pending_end", 8'h00, {7'h00, snap_pending});
         host.read_reg(holes[i % 5], s);
         check("unmapped", motion_status_pkg::UNMAPPED_RD, s);
      end
      $display("test random polls done");
      // Back-to-back status reads with events landing on the first one
      ex = 8'($urandom);
      ey = 8'($urandom);
      live_x = ~ex;
      live_y = ~ey;
      fork
         host.read_pair(motion_status_pkg::ADDR_STATUS,
                        motion_status_pkg::ADDR_STATUS, s, s2);
         begin
            @(negedge clk_sys);
            motion_event = 1'b1;
            x_ovf_event = 1'b1;
            @(negedge clk_sys);
            motion_event = 1'b0;
            x_ovf_event = 1'b0;
            live_x = ex;
            live_y = ey;
         end
      join
      check("race1", stat(1'h0, 1'h0, 1'h0, cpi_select_field), s);
      check("race2", stat(1'h1, 1'h0, 1'h1, cpi_select_field), s2);
      host.read_reg(motion_status_pkg::ADDR_DELTA_X, x);
      host.read_reg(motion_status_pkg::ADDR_DELTA_Y, y);
      check("refreeze_x", ex, x);
      check("refreeze_y", ey, y);
      // Delta X read in the cycle right after the status read
      live_x = ~ex;
      host.read_pair(motion_status_pkg::ADDR_STATUS,
                     motion_status_pkg::ADDR_DELTA_X, s, x);
      check("burst_status", stat(1'h0, 1'h0, 1'h0, cpi_select_field), s);
      check("burst_x", ~ex, x);
      host.read_reg(motion_status_pkg::ADDR_DELTA_Y, y);
      check("burst_y", ey, y);
      $display("test corner cases done");
      give_verdict();
   end
endmodule
